// [verilog/strap_eeprom_loader.v]
// strap sampling and serial configuration memory loader
//
// Notes on behaviour
// - we make the serial memory clock and drive it while loading.
// - command, address bits leave on the serial out pin, MSB first.
// - memory read bits are captured from the serial in pin.
// - select goes low for an access, high between and after accesses.
// - select pin sampled at init; low skips all loading, high enables.
// - payload strap high reports 512 bytes, low reports 256 bytes.
// - management data and clock lines are only pulled low or released.
// - system reset low clears all state, straps and sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "strap_loader_defines.vh"

module strap_eeprom_loader #(
   parameter ADDR_W = `EE_ADDR_W,
   parameter DATA_W = `EE_DATA_W,
   parameter WORDS = `EE_WORDS,
   parameter FIFO_DEPTH = `FIFO_DEPTH,
   parameter FIFO_AW = 4,
   parameter INIT_CYCLES = `INIT_CYCLES,
   parameter HALF_CYCLES = `EE_HALF_CYCLES,
   parameter GAP_CYCLES = `CS_GAP_CYCLES
) (
   // clock and reset
   input wire clk,
   input wire rst,
   input wire systemResetN,
   // serial memory pins
   output reg eepromSerialClock,
   output wire eepromSerialClockOe,
   output wire eepromSerialOut,
   input wire eepromSerialIn,
   input wire eepromSelectNIn,
   output reg eepromSelectN,
   output reg eepromSelectNOe,
   // straps
   input wire payloadCapStrap,
   // management bus pins
   input wire sclIn,
   output wire sclOut,
   output wire sclOe,
   input wire sdaIn,
   output wire sdaOut,
   output wire sdaOe,
   // management bus user side
   input wire sclPullLow,
   input wire sdaPullLow,
   output reg sclLevel,
   output reg sdaLevel,
   // configuration word stream
   output wire wordValid,
   input wire wordReady,
   output wire [DATA_W-1:0] wordData,
   // status
   output reg loaderEnabled,
   output reg loadDone,
   output reg maxPayload512,
   output reg [2:0] maxPayloadCode
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [5:0] ST_INIT = 6'h01;
   localparam [5:0] ST_WAIT = 6'h02;
   localparam [5:0] ST_CMD = 6'h04;
   localparam [5:0] ST_READ = 6'h08;
   localparam [5:0] ST_GAP = 6'h10;
   localparam [5:0] ST_DONE = 6'h20;
   localparam CMD_W = 3 + ADDR_W;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   reg resetMeta, resetSync;
   reg selMeta, loaderSkipStrapN;
   reg capMeta, capSync;
   reg dinMeta, dinSync;
   reg sclMeta, sdaMeta;
   wire localRst;

   // pins are asynchronous to clk, two flops each
   always @(posedge clk) begin
      if (rst) begin
         resetMeta <= 1'b0;
         resetSync <= 1'b0;
      end else begin
         resetMeta <= systemResetN;
         resetSync <= resetMeta;
      end
   end

   assign localRst = rst || !resetSync;

   always @(posedge clk) begin
      if (localRst) begin
         selMeta <= 1'b1;
         loaderSkipStrapN <= 1'b1;
         capMeta <= 1'b0;
         capSync <= 1'b0;
         dinMeta <= 1'b0;
         dinSync <= 1'b0;
         sclMeta <= 1'b1;
         sclLevel <= 1'b1;
         sdaMeta <= 1'b1;
         sdaLevel <= 1'b1;
      end else begin
         selMeta <= eepromSelectNIn;
         loaderSkipStrapN <= selMeta;
         capMeta <= payloadCapStrap;
         capSync <= capMeta;
         dinMeta <= eepromSerialIn;
         dinSync <= dinMeta;
         sclMeta <= sclIn;
         sclLevel <= sclMeta;
         sdaMeta <= sdaIn;
         sdaLevel <= sdaMeta;
      end
   end

   // ------------------------------------------------------------
   // management bus, open drain
   // ------------------------------------------------------------
   // never driven high: the external pull-up makes the high level
   assign sclOut = 1'b0;
   assign sclOe = sclPullLow;
   assign sdaOut = 1'b0;
   assign sdaOe = sdaPullLow;

   // ------------------------------------------------------------
   // serial clock divider
   // ------------------------------------------------------------
   reg [5:0] state;
   wire halfTick;
   wire shifting;

   assign shifting = (state == ST_CMD) || (state == ST_READ);

   tick_divider #(
      .DIV(HALF_CYCLES)
   ) halfDivider (
      .clk(clk),
      .rst(localRst),
      .enable(shifting),
      .tick(halfTick)
   );

   // ------------------------------------------------------------
   // word buffer
   // ------------------------------------------------------------
   reg fifoInValid;
   reg [DATA_W-1:0] readShift;
   wire fifoInReady;

   word_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) wordBuffer (
      .clk(clk),
      .rst(localRst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(readShift),
      .outValid(wordValid),
      .outReady(wordReady),
      .outData(wordData)
   );

   // ------------------------------------------------------------
   // loader sequencer
   // ------------------------------------------------------------
   reg [15:0] waitCount;
   reg [7:0] bitCount;
   reg [ADDR_W:0] wordIndex;
   reg [CMD_W-1:0] cmdShift;
   wire lastBit;
   wire lastWord;

   assign eepromSerialOut = cmdShift[CMD_W-1];
   assign eepromSerialClockOe = loaderEnabled && !loadDone;
   assign lastWord = (wordIndex == WORDS[ADDR_W:0]);
   assign lastBit = (state == ST_CMD) ?
      (bitCount == CMD_W[7:0] - 8'h01) :
      (bitCount == DATA_W[7:0] - 8'h01);

   always @(posedge clk) begin
      if (localRst) begin
         // everything here clears while the system reset is low
         state <= ST_INIT;
         waitCount <= 16'h0000;
         bitCount <= 8'h00;
         wordIndex <= {(ADDR_W+1){1'b0}};
         cmdShift <= {CMD_W{1'b0}};
         readShift <= {DATA_W{1'b0}};
         fifoInValid <= 1'b0;
         eepromSerialClock <= 1'b0;
         eepromSelectN <= 1'b1;
         eepromSelectNOe <= 1'b0;
         loaderEnabled <= 1'b0;
         loadDone <= 1'b0;
         maxPayload512 <= 1'b0;
         maxPayloadCode <= `MPS_CODE_256;
      end else begin
         fifoInValid <= 1'b0;
         case (state)
            ST_INIT: begin
               // select pin stays released while it acts as a strap
               if (waitCount == INIT_CYCLES[15:0] - 16'h0001) begin
                  waitCount <= 16'h0000;
                  loaderEnabled <= loaderSkipStrapN;
                  maxPayload512 <= capSync;
                  maxPayloadCode <= capSync ? `MPS_CODE_512 :
                     `MPS_CODE_256;
                  if (loaderSkipStrapN) begin
                     // a tied-low strap would fight a driven high
                     eepromSelectNOe <= 1'b1;
                     eepromSelectN <= 1'b1;
                     state <= ST_WAIT;
                  end else begin
                     loadDone <= 1'b1;
                     state <= ST_DONE;
                  end
               end else begin
                  waitCount <= waitCount + 16'h0001;
               end
            end
            ST_WAIT: begin
               // stall between words while the buffer is full
               if (fifoInReady) begin
                  cmdShift <= {`EE_START_BIT, `EE_OPCODE_READ,
                     wordIndex[ADDR_W-1:0]};
                  bitCount <= 8'h00;
                  eepromSelectN <= 1'b0;
                  state <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (halfTick) begin
                  eepromSerialClock <= !eepromSerialClock;
                  // data changes on the falling edge only
                  if (eepromSerialClock) begin
                     cmdShift <= {cmdShift[CMD_W-2:0], 1'b0};
                     if (lastBit) begin
                        bitCount <= 8'h00;
                        state <= ST_READ;
                     end else begin
                        bitCount <= bitCount + 8'h01;
                     end
                  end
               end
            end
            ST_READ: begin
               if (halfTick) begin
                  eepromSerialClock <= !eepromSerialClock;
                  // sample late in the high phase, sync lag included
                  if (eepromSerialClock) begin
                     readShift <= {readShift[DATA_W-2:0], dinSync};
                     if (lastBit) begin
                        fifoInValid <= 1'b1;
                        eepromSelectN <= 1'b1;
                        wordIndex <= wordIndex + 1'b1;
                        waitCount <= 16'h0000;
                        state <= ST_GAP;
                     end else begin
                        bitCount <= bitCount + 8'h01;
                     end
                  end
               end
            end
            ST_GAP: begin
               if (waitCount == GAP_CYCLES[15:0] - 16'h0001) begin
                  waitCount <= 16'h0000;
                  if (lastWord) begin
                     loadDone <= 1'b1;
                     state <= ST_DONE;
                  end else begin
                     state <= ST_WAIT;
                  end
               end else begin
                  waitCount <= waitCount + 16'h0001;
               end
            end
            ST_DONE: begin
               eepromSerialClock <= 1'b0;
               eepromSelectN <= 1'b1;
            end
            default: begin
               state <= ST_INIT;
            end
         endcase
      end
   end

endmodule // strap_eeprom_loader

`default_nettype wire

// [verilog/strap_loader_defines.vh]
// constants shared by the strap sampler and configuration loader
`ifndef STRAP_LOADER_DEFINES_VH
`define STRAP_LOADER_DEFINES_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 40
// strap sampling window after system reset release
`define INIT_TIME_NS 20000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// half period of the serial clock, least time
`define EE_HALF_NS 160
`define EE_HALF_CYCLES ((`EE_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// select high time between two accesses, least time
`define CS_GAP_NS 250
`define CS_GAP_CYCLES ((`CS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ------------------------------------------------------------
// serial memory command layout
// ------------------------------------------------------------
`define EE_START_BIT 1'h1
`define EE_OPCODE_READ 2'h2
`define EE_ADDR_W 6
`define EE_DATA_W 16
`define EE_WORDS 64

// ------------------------------------------------------------
// buffering and payload codes
// ------------------------------------------------------------
`define FIFO_DEPTH 16
`define MPS_CODE_256 3'h1
`define MPS_CODE_512 3'h2

`endif

// [verilog/tick_divider.v]
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
   parameter DIV = 4
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // control
   input wire enable,
   output reg tick
);

   reg [15:0] count;

   // restart on enable so the first tick is a full period later
   always @(posedge clk) begin
      if (rst || !enable) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (count == DIV[15:0] - 16'h0001) begin
         count <= 16'h0000;
         tick <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule // tick_divider

`default_nettype wire

// [verilog/word_fifo.v]
// flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               rdPtr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule // word_fifo

`default_nettype wire

// [bench/strap_loader_monitor.sv]
// port assertions for the strap sampler and loader
`timescale 1ns/1ps
`default_nettype none
module strap_loader_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic systemResetN,
   // serial memory pins
   input wire logic eepromSerialClock,
   input wire logic eepromSerialClockOe,
   input wire logic eepromSerialOut,
   input wire logic eepromSelectN,
   input wire logic eepromSelectNOe,
   // management bus
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sclPullLow,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic sdaPullLow,
   // status
   input wire logic wordValid,
   input wire logic loaderEnabled,
   input wire logic loadDone,
   input wire logic maxPayload512,
   input wire logic [2:0] maxPayloadCode
);
   // ------------------------------------------------------------
   // sequences and checks
   // ------------------------------------------------------------
   // system reset lags through its synchroniser, so both mask checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !systemResetN);
   // reset seen one edge back; starts low so the first edge stays quiet
   logic rstSeen = 1'b0;
   always @(posedge clk) begin
      rstSeen <= rst;
   end
   sequence clkHigh;
      eepromSerialClock[*4] ##1 !eepromSerialClock;
   endsequence
   sequence selGap;
      eepromSelectN[*7];
   endsequence
   chk_start_bit: assert property (
      $fell(eepromSelectN) |-> eepromSerialOut)
      else $error("start bit not high at select fall");
   chk_idle_clock: assert property (
      eepromSelectN |-> !eepromSerialClock)
      else $error("serial clock high while deselected");
   chk_half_period: assert property (
      $rose(eepromSerialClock) |-> clkHigh)
      else $error("serial clock high phase wrong length");
   chk_out_stable: assert property (
      !eepromSelectN && !$past(eepromSelectN) && $changed(eepromSerialOut)
      |-> $fell(eepromSerialClock))
      else $error("serial out moved off a falling edge");
   chk_select_gap: assert property (
      $rose(eepromSelectN) |=> selGap)
      else $error("select high gap too short");
   chk_skip_released: assert property (
      !loaderEnabled && loadDone |-> !eepromSelectNOe && !eepromSerialClockOe)
      else $error("pins driven after skipped load");
   chk_payload_code: assert property (
      maxPayloadCode == (maxPayload512 ? 3'h2 : 3'h1))
      else $error("payload code disagrees with strap");
   chk_sda_open: assert property (
      !sdaOut && sdaOe == sdaPullLow)
      else $error("data line driven high or enable wrong");
   chk_scl_open: assert property (
      !sclOut && sclOe == sclPullLow)
      else $error("clock line driven high or enable wrong");
   chk_reset_clears: assert property (disable iff (1'b0)
      rst && rstSeen |-> !loaderEnabled && !loadDone && !wordValid
      && eepromSelectN && !eepromSerialClock)
      else $error("state not cleared in reset");
   chk_latch_once: assert property (
      loaderEnabled |=> loaderEnabled)
      else $error("strap latch changed without reset");
   chk_select_oe: assert property (
      eepromSelectNOe |-> loaderEnabled)
      else $error("select driven while loading disabled");
endmodule // strap_loader_monitor
bind strap_eeprom_loader strap_loader_monitor i_strap_loader_monitor (.*);
`default_nettype wire

// [bench/eeprom_model.sv]
// behavioural serial configuration memory
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
   // serial pins
   input wire logic serialClock,
   input wire logic selectN,
   input wire logic dataIn,
   output logic dataOut
);
   logic [4:0] cnt = 5'h0;
   logic [8:0] cmd = 9'h0;
   logic [15:0] word;
   // stands still outside a read, so drive the inverse of the last bit
   initial dataOut = 1'b0;
   assign word = {~cmd[5:0], 4'h5, cmd[5:0]};
   always @(posedge serialClock or posedge selectN) begin
      if (selectN) begin
         cnt <= 5'h0;
         dataOut <= ~dataOut;
      end else begin
         cnt <= cnt + 5'h1;
         if (cnt < 5'h9)
            cmd <= {cmd[7:0], dataIn};
         else if (cnt < 5'h19)
            // a wrong command reads back inverted data
            dataOut <= word[5'h18 - cnt] ^ (cmd[8:6] != 3'h6);
      end
   end
endmodule // eeprom_model
`default_nettype wire

// [bench/strap_eeprom_loader_bench.sv]
// self-checking bench for the strap sampler and loader
`timescale 1ns/1ps
`default_nettype none
module strap_eeprom_loader_bench;
   logic clk = 0, rst = 1, systemResetN = 0, payloadCapStrap = 0;
   logic selStrap = 1, sclPullLow = 0, sdaPullLow = 0, wordReady = 0;
   logic eepromSerialClock, eepromSerialClockOe, eepromSerialOut;
   logic eepromSerialIn, eepromSelectN, eepromSelectNOe;
   logic sclOut, sclOe, sdaOut, sdaOe, sclLevel, sdaLevel;
   logic wordValid, loaderEnabled, loadDone, maxPayload512;
   logic [15:0] wordData;
   logic [2:0] maxPayloadCode;
   logic [16:0] seed = 17'h115DC;
   logic [15:0] expQ[$];
   int badCount = 0, nTests = 0;
   // strap on the shared select pin, set high or low by selStrap; pull-ups on the bus lines
   wire eepromSelectNIn = eepromSelectNOe ? eepromSelectN : selStrap;
   wire sclIn = !sclOe;
   wire sdaIn = !sdaOe;
   // ------------------------------------------------------------
   // clock, design and memory
   // ------------------------------------------------------------
   initial forever #20 clk = ~clk;
   strap_eeprom_loader #(.INIT_CYCLES(8)) i_strap_eeprom_loader (.*);
   eeprom_model i_eeprom_model (
      .serialClock(eepromSerialClock),
      .selectN(eepromSelectNIn),
      .dataIn(eepromSerialOut),
      .dataOut(eepromSerialIn));
   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] e, g);
      nTests++;
      if (g !== e) begin
         badCount++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask
   always @(posedge clk) begin
      if (!rst && systemResetN && wordValid === 1'b1 && wordReady) begin
         if (expQ.size() == 0)
            chk("extra word", 16'h0, 16'hFFFF);
         else
            chk("word", expQ.pop_front(), wordData);
      end
   end
   task automatic printVerdict;
      $display("comparisons %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   task automatic startRun(input logic en, pl, sys);
      // one edge apart from the last drain step, which sets wordReady too
      @(posedge clk);
      wordReady <= 0;
      selStrap <= en;
      payloadCapStrap <= pl;
      if (sys)
         systemResetN <= 0;
      else
         rst <= 1;
      repeat (12) @(posedge clk);
      expQ.delete();
      rst <= 0;
      systemResetN <= 1;
      repeat (20) @(posedge clk);
      chk("enabled", en, loaderEnabled);
      chk("pl512", pl, maxPayload512);
      chk("code", pl ? 3'h2 : 3'h1, maxPayloadCode);
      chk("done", !en, loadDone);
      chk("selOe", en, eepromSelectNOe);
      chk("clkOe", en, eepromSerialClockOe);
      if (en)
         for (int i = 0; i < 64; i++)
            expQ.push_back({~i[5:0], 4'h5, i[5:0]});
   endtask
   task automatic drain(input int n, input logic must);
      int k;
      for (k = 0; k < n; k++) begin
         @(posedge clk);
         seed = lfsr(seed);
         wordReady <= seed[0];
         sclPullLow <= seed[1];
         sdaPullLow <= seed[2];
         if (loadDone === 1'b1 && expQ.size() == 0 && !wordValid)
            break;
      end
      if (must && k == n)
         chk("load finished", 16'h1, 16'h0);
   endtask
   initial begin
      startRun(1, 1, 0);
      // fifo fills and the loader must hold select high meanwhile
      repeat (6000) @(posedge clk);
      chk("full valid", 1, wordValid);
      chk("held select", 1, eepromSelectN);
      chk("queued", 64, expQ.size());
      drain(30000, 1);
      chk("left", 0, expQ.size());
      // abort a load in mid-word by system reset
      startRun(1, 0, 1);
      drain(1500, 0);
      startRun(0, 0, 1);
      drain(300, 0);
      chk("skip valid", 0, wordValid);
      chk("skip select", 0, eepromSelectNOe);
      // a pulled line reads back low, a released one high via its pull-up
      @(posedge clk);
      sclPullLow <= 1;
      sdaPullLow <= 0;
      repeat (4) @(posedge clk);
      chk("scl level", 0, sclLevel);
      chk("sda level", 1, sdaLevel);
      printVerdict();
   end
endmodule // strap_eeprom_loader_bench
`default_nettype wire
